// File: hw/regulator_ctrl_regs.sv
// rail control register bank: second linear rail, card-supply rail, 3.3 v rail
`timescale 1ns/1ns
module regulator_ctrl_regs (
	input wire logic clock_i,
	input wire logic reset_i,
	input regulator_ctrl_pkg::reg_req_s req_i,
	input wire logic [3:0] page_i,
	input wire logic [4:0] otp_rail_b_i,
	input wire logic [2:0] otp_card_i,
	input wire logic [2:0] otp_3v3_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output logic ready_o,
	output regulator_ctrl_pkg::rail_ctrl_s rail_b_o,
	output regulator_ctrl_pkg::rail_ctrl_s card_rail_o,
	output regulator_ctrl_pkg::rail_ctrl_s rail_3v3_o
);
	logic load;
	logic loaded;
	logic page_ok;
	logic [2:0] hit;
	logic [7:0] val_b;
	logic [7:0] val_card;
	logic [7:0] val_3v3;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic ready_q;
	regulator_ctrl_pkg::rail_ctrl_s rail_b_q;
	regulator_ctrl_pkg::rail_ctrl_s card_q;
	regulator_ctrl_pkg::rail_ctrl_s v33_q;

	// register word to decoded fields; used for all three rails
	function automatic regulator_ctrl_pkg::rail_ctrl_s unpack(input logic [7:0] w);
		regulator_ctrl_pkg::rail_ctrl_s r;
		r.off_mode = w[regulator_ctrl_pkg::BIT_OFF_MODE];
		r.lowpower_en = w[regulator_ctrl_pkg::BIT_LOWPOWER];
		r.standby_off = w[regulator_ctrl_pkg::BIT_STANDBY];
		r.enable = w[regulator_ctrl_pkg::BIT_ENABLE];
		r.voltage_sel = w[3:0];
		return r;
	endfunction : unpack

	otp_loader u_loader (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.load_o(load),
		.done_o(loaded)
	);

	// only the functional page reaches this bank
	assign page_ok = (page_i == regulator_ctrl_pkg::PAGE_FUNCTIONAL);
	assign hit[0] = page_ok && (req_i.addr == regulator_ctrl_pkg::ADDR_RAIL_B);
	assign hit[1] = page_ok && (req_i.addr == regulator_ctrl_pkg::ADDR_CARD);
	assign hit[2] = page_ok && (req_i.addr == regulator_ctrl_pkg::ADDR_3V3);

	rail_ctrl_reg #(.WMASK(regulator_ctrl_pkg::MASK_RAIL_B)) u_rail_b (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.otp_i(otp_rail_b_i),
		.load_i(load),
		.we_i(req_i.wr && hit[0] && loaded),
		.wdata_i(req_i.wdata),
		.value_o(val_b)
	);

	rail_ctrl_reg #(.WMASK(regulator_ctrl_pkg::MASK_NARROW)) u_card (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.otp_i({otp_card_i[2], 2'b00, otp_card_i[1:0]}),
		.load_i(load),
		.we_i(req_i.wr && hit[1] && loaded),
		.wdata_i(req_i.wdata),
		.value_o(val_card)
	);

	rail_ctrl_reg #(.WMASK(regulator_ctrl_pkg::MASK_NARROW)) u_3v3 (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.otp_i({otp_3v3_i[2], 2'b00, otp_3v3_i[1:0]}),
		.load_i(load),
		.we_i(req_i.wr && hit[2] && loaded),
		.wdata_i(req_i.wdata),
		.value_o(val_3v3)
	);

	// read data registered; unmapped or wrong-page reads return zero
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rdata_q <= 8'h0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= req_i.rd && loaded;
			if (req_i.rd && loaded) begin
				unique case (1'b1)
					hit[0]: rdata_q <= val_b;
					hit[1]: rdata_q <= val_card;
					hit[2]: rdata_q <= val_3v3;
					default: rdata_q <= 8'h0000;
				endcase
			end
		end
	end

	// ready rises one cycle after otp defaults are in; accesses before the defaults are in are ignored
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= loaded;
		end
	end

	// field outputs registered so they come straight from flops
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rail_b_q <= '0;
			card_q <= '0;
			v33_q <= '0;
		end else begin
			rail_b_q <= unpack(val_b);
			card_q <= unpack(val_card);
			v33_q <= unpack(val_3v3);
		end
	end

	assign rdata_o = rdata_q;
	assign rvalid_o = rvalid_q;
	assign ready_o = ready_q;
	assign rail_b_o = rail_b_q;
	assign card_rail_o = card_q;
	assign rail_3v3_o = v33_q;

	// written value appears on field outputs two cycles later
	property p_card_write;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[1] && loaded) |-> ##2
			(card_rail_o.enable == $past(req_i.wdata[4], 2)); 
	endproperty
	a_card_write: assert property (p_card_write) else $error("card enable not written");

	property p_card_resv;
		@(posedge clock_i) disable iff (reset_i) val_card[3:2] == 2'b00;
	endproperty
	a_card_resv: assert property (p_card_resv) else $error("card reserved bits set");

	property p_3v3_resv;
		@(posedge clock_i) disable iff (reset_i) val_3v3[3:2] == 2'b00;
	endproperty
	a_3v3_resv: assert property (p_3v3_resv) else $error("3v3 reserved bits set");

	property p_b_mode;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[0] && loaded) |-> ##2 (rail_b_o.off_mode == $past(req_i.wdata[7], 2));
	endproperty
	a_b_mode: assert property (p_b_mode) else $error("rail b off mode wrong");

	property p_b_volt;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[0] && loaded) |-> ##1 (val_b[3:0] == $past(req_i.wdata[3:0]));
	endproperty
	a_b_volt: assert property (p_b_volt) else $error("rail b voltage wrong");

	property p_3v3_lp;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[2] && loaded) |-> ##1 (val_3v3[6:5] == $past(req_i.wdata[6:5]));
	endproperty
	a_3v3_lp: assert property (p_3v3_lp) else $error("3v3 lowpower or standby wrong");

	property p_load_clear;
		@(posedge clock_i) disable iff (reset_i)
		load |-> ##1 (val_card[7:5] == 3'b000 && val_b[7:5] == 3'b000);
	endproperty
	a_load_clear: assert property (p_load_clear) else $error("mode bits not clear at load");

	property p_read_card;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.rd && hit[1] && loaded) |=> (rvalid_o && rdata_o == $past(val_card));
	endproperty
	a_read_card: assert property (p_read_card) else $error("card read wrong");

	property p_page;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.rd && !page_ok && loaded) |=> (rdata_o == 8'h0000);
	endproperty
	a_page: assert property (p_page) else $error("off-page read not zero");

	// every field of every rail reaches its output two cycles after the write is taken
	property p_b_lowpower;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[0] && loaded) |-> ##2
			(rail_b_o.lowpower_en == $past(req_i.wdata[6], 2));
	endproperty
	a_b_lowpower: assert property (p_b_lowpower) else $error("rail b lowpower wrong");

	property p_b_standby;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[0] && loaded) |-> ##2
			(rail_b_o.standby_off == $past(req_i.wdata[5], 2));
	endproperty
	a_b_standby: assert property (p_b_standby) else $error("rail b standby wrong");

	property p_b_enable;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[0] && loaded) |-> ##2
			(rail_b_o.enable == $past(req_i.wdata[4], 2));
	endproperty
	a_b_enable: assert property (p_b_enable) else $error("rail b enable wrong");

	property p_b_volt_out;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[0] && loaded) |-> ##2
			(rail_b_o.voltage_sel == $past(req_i.wdata[3:0], 2));
	endproperty
	a_b_volt_out: assert property (p_b_volt_out) else $error("rail b volt out wrong");

	property p_card_mode;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[1] && loaded) |-> ##2
			(card_rail_o.off_mode == $past(req_i.wdata[7], 2));
	endproperty
	a_card_mode: assert property (p_card_mode) else $error("card off mode wrong");

	property p_card_lowpower;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[1] && loaded) |-> ##2
			(card_rail_o.lowpower_en == $past(req_i.wdata[6], 2));
	endproperty
	a_card_lowpower: assert property (p_card_lowpower) else $error("card lowpower wrong");

	property p_card_standby;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[1] && loaded) |-> ##2
			(card_rail_o.standby_off == $past(req_i.wdata[5], 2));
	endproperty
	a_card_standby: assert property (p_card_standby) else $error("card standby wrong");

	// narrow rails must show zero in 3:2 whatever was written there
	property p_card_volt;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[1] && loaded) |-> ##2
			(card_rail_o.voltage_sel == {2'b00, $past(req_i.wdata[1:0], 2)});
	endproperty
	a_card_volt: assert property (p_card_volt) else $error("card volt wrong");

	property p_3v3_mode;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[2] && loaded) |-> ##2
			(rail_3v3_o.off_mode == $past(req_i.wdata[7], 2));
	endproperty
	a_3v3_mode: assert property (p_3v3_mode) else $error("3v3 off mode wrong");

	property p_3v3_lowpower;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[2] && loaded) |-> ##2
			(rail_3v3_o.lowpower_en == $past(req_i.wdata[6], 2));
	endproperty
	a_3v3_lowpower: assert property (p_3v3_lowpower) else $error("3v3 lowpower wrong");

	property p_3v3_standby;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[2] && loaded) |-> ##2
			(rail_3v3_o.standby_off == $past(req_i.wdata[5], 2));
	endproperty
	a_3v3_standby: assert property (p_3v3_standby) else $error("3v3 standby wrong");

	property p_3v3_enable;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[2] && loaded) |-> ##2
			(rail_3v3_o.enable == $past(req_i.wdata[4], 2));
	endproperty
	a_3v3_enable: assert property (p_3v3_enable) else $error("3v3 enable wrong");

	property p_3v3_volt;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.wr && hit[2] && loaded) |-> ##2
			(rail_3v3_o.voltage_sel == {2'b00, $past(req_i.wdata[1:0], 2)});
	endproperty
	a_3v3_volt: assert property (p_3v3_volt) else $error("3v3 volt wrong");

	// reads of the other two rails, idle rvalid, reset state and otp load
	property p_read_b;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.rd && hit[0] && loaded) |=>
			(rvalid_o && rdata_o == $past(val_b));
	endproperty
	a_read_b: assert property (p_read_b) else $error("rail b read wrong");

	property p_read_3v3;
		@(posedge clock_i) disable iff (reset_i)
		(req_i.rd && hit[2] && loaded) |=>
			(rvalid_o && rdata_o == $past(val_3v3));
	endproperty
	a_read_3v3: assert property (p_read_3v3) else $error("3v3 read wrong");

	property p_rvalid_idle;
		@(posedge clock_i) disable iff (reset_i)
		!(req_i.rd && loaded) |=>
			!rvalid_o;
	endproperty
	a_rvalid_idle: assert property (p_rvalid_idle) else $error("rvalid without read");

	property p_reset_clear;
		@(posedge clock_i)
		reset_i |=> (rail_b_o == '0 && card_rail_o == '0 && rail_3v3_o == '0
			&& !ready_o && !rvalid_o && rdata_o == 8'h00);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear in reset");

	property p_load_otp;
		@(posedge clock_i) disable iff (reset_i)
		load |=> (val_b[4:0] == $past(otp_rail_b_i) && val_card[4] == $past(otp_card_i[2])
			&& val_3v3[4] == $past(otp_3v3_i[2]) && val_3v3[1:0] == $past(otp_3v3_i[1:0]));
	endproperty
	a_load_otp: assert property (p_load_otp) else $error("otp defaults not loaded");

	property p_ready_level;
		@(posedge clock_i) disable iff (reset_i)
		loaded |=>
			ready_o;
	endproperty
	a_ready_level: assert property (p_ready_level) else $error("ready low after load");

	c_wr_card: cover property (@(posedge clock_i) req_i.wr && hit[1] && loaded);
	c_rd_3v3: cover property (@(posedge clock_i) req_i.rd && hit[2] && loaded);
	c_wr_b: cover property (@(posedge clock_i) req_i.wr && hit[0] && loaded);
	c_load: cover property (@(posedge clock_i) load);
	c_rd_off_page: cover property (@(posedge clock_i) req_i.rd && !page_ok && loaded);
endmodule : regulator_ctrl_regs

// File: pkg/regulator_ctrl_pkg.sv
// package: register map, field layout and reset values of the rail control bank
// Operation
// - rail b bit 7: enable-pin turn-off sends rail off (0) or to sleep (1).
// - rail b bit 6: 1 allows low-power mode, 0 forbids it.
// - rail b bit 5: 1 turns rail off in standby, 0 keeps it on.
// - rail b bit 4: rail enable, 1 on, 0 off.
// - rail b bits 3:0: four-bit output voltage code.
// - card rail register sits at 0x6E, read and write any time; accesses are ignored until otp defaults are in.
// - card rail bit 7: enable-pin turn-off sends rail off or to sleep.
// - card rail bit 6: low-power mode permitted when set.
// - card rail bit 5: rail off during standby when set.
// - card rail bit 4: regulator enable.
// - card rail bits 1:0 voltage code; bits 3:2 unimplemented, zero.
// - 3.3 V rail register sits at 0x6F, read and write any time; accesses are ignored until otp defaults are in.
// - 3.3 V rail bit 7: enable-pin turn-off sends rail off or to sleep.
// - 3.3 V rail bit 6: low-power mode permitted when set.
// - 3.3 V rail bit 5: rail off during standby when set.
// - 3.3 V rail bit 4: regulator enable.
// - 3.3 V rail bits 1:0 voltage code; bits 3:2 reserved, zero.
// - reset clears mode, low-power, standby bits; enable and voltage from otp.
package regulator_ctrl_pkg;
	localparam logic [7:0] ADDR_RAIL_B = 8'h006D;
	localparam logic [7:0] ADDR_CARD = 8'h006E;
	localparam logic [7:0] ADDR_3V3 = 8'h006F;
	localparam logic [3:0] PAGE_FUNCTIONAL = 4'h0;
	localparam int BIT_OFF_MODE = 7;
	localparam int BIT_LOWPOWER = 6;
	localparam int BIT_STANDBY = 5;
	localparam int BIT_ENABLE = 4;
	// writable bit masks per register; zero bits are reserved
	localparam logic [7:0] MASK_RAIL_B = 8'h00FF;
	localparam logic [7:0] MASK_NARROW = 8'h00F3;
	localparam logic [7:0] RESET_FIXED = 8'h0000;

	// one rail's decoded controls
	typedef struct packed {
		logic off_mode;
		logic lowpower_en;
		logic standby_off;
		logic enable;
		logic [3:0] voltage_sel;
	} rail_ctrl_s;

	// register access request from the serial port engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;
endpackage : regulator_ctrl_pkg

// File: hw/rail_ctrl_reg.sv
// one eight-bit rail control register with otp-loaded reset fields
`timescale 1ns/1ns
module rail_ctrl_reg #(
	parameter logic [7:0] WMASK = 8'h00FF
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [4:0] otp_i,
	input wire logic load_i,
	input wire logic we_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] value_o
);
	logic [7:0] value_q;
	logic [7:0] otp_word;

	// otp gives enable then voltage code; masked so narrow rails keep 3:2 at zero
	assign otp_word = {3'b000, otp_i} & WMASK;

	// reset clears mode bits to a constant; otp is taken by a clocked load after release
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			value_q <= regulator_ctrl_pkg::RESET_FIXED;
		end else if (load_i) begin
			value_q <= otp_word;
		end else if (we_i) begin
			value_q <= wdata_i & WMASK;
		end
	end

	assign value_o = value_q;
endmodule : rail_ctrl_reg

// File: hw/otp_loader.sv
// one-shot strobe that loads otp defaults on the first cycle after reset
`timescale 1ns/1ns
module otp_loader (
	input wire logic clock_i,
	input wire logic reset_i,
	output logic load_o,
	output logic done_o
);
	logic done_q;
	logic load_q;

	// pulse once after release, then hold done
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			done_q <= 1'b0;
			load_q <= 1'b0;
		end else begin
			load_q <= ~done_q;
			done_q <= 1'b1;
		end
	end

	assign load_o = load_q;
	assign done_o = done_q & ~load_q;
endmodule : otp_loader

// File: tb/tb_regulator_ctrl_regs.sv
// self-checking testbench for the rail control register bank
`timescale 1ns/1ns
module tb_regulator_ctrl_regs;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	regulator_ctrl_pkg::reg_req_s req_i = '0;
	logic [3:0] page_i = 4'h0;
	logic [4:0] otp_rail_b_i = 5'h1A;
	logic [2:0] otp_card_i = 3'h6;
	logic [2:0] otp_3v3_i = 3'h1;
	logic [7:0] rdata_o;
	logic rvalid_o;
	logic ready_o;
	regulator_ctrl_pkg::rail_ctrl_s rail_b_o;
	regulator_ctrl_pkg::rail_ctrl_s card_rail_o;
	regulator_ctrl_pkg::rail_ctrl_s rail_3v3_o;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [7:0] rd;
	logic [7:0] pats [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0F, 8'h0C};
	logic [7:0] addrs [3] = '{8'h6D, 8'h6E, 8'h6F};
	logic [7:0] masks [3] = '{8'hFF, 8'hF3, 8'hF3};

	regulator_ctrl_regs uut (
		.clock_i(clock_i), .reset_i(reset_i), .req_i(req_i), .page_i(page_i),
		.otp_rail_b_i(otp_rail_b_i), .otp_card_i(otp_card_i), .otp_3v3_i(otp_3v3_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .ready_o(ready_o),
		.rail_b_o(rail_b_o), .card_rail_o(card_rail_o), .rail_3v3_o(rail_3v3_o)
	);

	// 40 ns clock
	always #20 clock_i = ~clock_i;

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// the bank takes a request on one edge; req is dropped right after it
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		req_i <= {1'b1, 1'b0, a, d};
		@(posedge clock_i);
		req_i <= '0;
	endtask : wr_reg

	// rvalid and rdata are settled just after the taking edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		req_i <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clock_i);
		req_i <= '0;
		#1;
		check("rvalid", {7'h00, rvalid_o}, 8'h01);
		d = rdata_o;
	endtask : rd_reg

	function automatic logic [7:0] rail_of(input int i);
		case (i)
			0: return rail_b_o;
			1: return card_rail_o;
			default: return rail_3v3_o;
		endcase
	endfunction : rail_of

	// release reset, wait for otp load, then compare defaults with the otp inputs
	task automatic reset_and_check();
		logic [7:0] e [3];
		logic [7:0] d;
		int n;
		repeat (15) @(posedge clock_i);
		#1;
		check("ready in reset", {7'h00, ready_o}, 8'h00);
		check("rail out in reset", rail_b_o, 8'h00);
		@(posedge clock_i);
		reset_i <= 1'b0;
		n = 0;
		while (ready_o !== 1'b1 && n < 50) begin
			@(posedge clock_i);
			n++;
		end
		check("ready after load", {7'h00, ready_o}, 8'h01);
		e[0] = {3'b000, otp_rail_b_i};
		e[1] = {3'b000, otp_card_i[2], 2'b00, otp_card_i[1:0]};
		e[2] = {3'b000, otp_3v3_i[2], 2'b00, otp_3v3_i[1:0]};
		for (int i = 0; i < 3; i++) begin
			rd_reg(addrs[i], d);
			check("default", d, e[i]);
			check("default rail", rail_of(i), e[i]);
		end
	endtask : reset_and_check

	// main sequence
	initial begin
		reset_and_check();
		// every field of every register, reserved bits included
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 6; j++) begin
				wr_reg(addrs[i], pats[j]);
				rd_reg(addrs[i], rd);
				check("readback", rd, pats[j] & masks[i]);
				check("rail", rail_of(i), pats[j] & masks[i]);
			end
		end
		// wrong page: write ignored, read gives zero
		wr_reg(8'h6E, 8'hF3);
		@(posedge clock_i);
		page_i <= 4'h1;
		wr_reg(8'h6E, 8'h00);
		rd_reg(8'h6E, rd);
		check("wrong page read", rd, 8'h00);
		@(posedge clock_i);
		page_i <= 4'h0;
		rd_reg(8'h6E, rd);
		check("wrong page write", rd, 8'hF3);
		// unmapped neighbours read zero
		wr_reg(8'h70, 8'hFF);
		rd_reg(8'h70, rd);
		check("unmapped 70", rd, 8'h00);
		rd_reg(8'h6C, rd);
		check("unmapped 6c", rd, 8'h00);
		// back-to-back writes on consecutive edges
		@(posedge clock_i);
		req_i <= {1'b1, 1'b0, 8'h6E, 8'h91};
		@(posedge clock_i);
		req_i <= {1'b1, 1'b0, 8'h6F, 8'h5E};
		@(posedge clock_i);
		req_i <= '0;
		rd_reg(8'h6E, rd);
		check("b2b card", rd, 8'h91);
		rd_reg(8'h6F, rd);
		check("b2b 3v3", rd, 8'h52);
		// second reset in mid-run with new otp defaults
		@(posedge clock_i);
		reset_i <= 1'b1;
		otp_rail_b_i <= 5'h05;
		otp_card_i <= 3'h3;
		otp_3v3_i <= 3'h6;
		reset_and_check();
		end_of_test();
	end
endmodule : tb_regulator_ctrl_regs
